// [shared/rx_desc_defines.vh]
`ifndef RX_DESC_DEFINES_VH
`define RX_DESC_DEFINES_VH

// Descriptor layout
`define DESC_WORDS         3'd4
`define DESC_W0_OFS        4'h0
`define DESC_W1_OFS        4'h4
`define DESC_W3_OFS        4'hc

// Word 0 fields
`define OWN_HI             31
`define OWN_LO             30
`define OWN_HOST           2'b00
`define OWN_MAC            2'b10
`define OWN_XLATE          2'b11
`define RUNT_BIT           22
`define ALIGN_BIT          21
`define DONE_BIT           20
`define LONG_BIT           19
`define CRC_BIT            17
`define EVENT_BIT          16

// Frame limits
`define MIN_FRAME_BYTES    16'h0040
`define MAX_FRAME_BYTES    16'h05ee
`define FCS_BYTES          16'h0004

`endif

// [logic/rx_descriptor_status_writeback.v]
`timescale 1ns/1ps
`include "rx_desc_defines.vh"

module rx_descriptor_status_writeback
(
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Control
    input  wire        enable,
    input  wire        strip_check_sequence,
    input  wire [31:0] first_descriptor,
    // Frame completion from receive path
    input  wire        frame_done,
    input  wire [15:0] frame_bytes,
    input  wire        frame_odd_bits,
    input  wire        frame_crc_bad,
    input  wire        frame_event,
    input  wire        frame_xlate,
    output wire        frame_ready,
    // Buffer handed to receive path
    output reg         buffer_valid,
    output reg  [31:0] receive_buffer_base,
    output reg  [1:0]  byte_offset_field,
    // Memory master
    output reg         mem_req,
    output reg         mem_we,
    output reg  [31:0] mem_addr,
    output reg  [31:0] mem_wdata,
    input  wire        mem_ack,
    input  wire [31:0] mem_rdata,
    // Status
    output reg  [31:0] current_descriptor,
    output reg         descriptor_wait
);

    // --------------------------------------------------------------
    // States
    // --------------------------------------------------------------
    localparam S_IDLE  = 3'd0;
    localparam S_RD0   = 3'd1;
    localparam S_RD1   = 3'd2;
    localparam S_RD3   = 3'd3;
    localparam S_RECV  = 3'd4;
    localparam S_WB    = 3'd5;
    localparam S_POLL  = 3'd6;

    // Walk state and the link taken from word 3
    reg  [2:0]  state;
    reg  [31:0] next_descriptor_pointer;
    // Word 0 image prepared for the write-back
    reg  [31:0] next_status;

    // --------------------------------------------------------------
    // Helper functions
    // --------------------------------------------------------------
    // Drop the two ignored low address bits
    function [31:0] word_align;
        input [31:0] addr;
        begin
            word_align = {addr[31:2], 2'b00};
        end
    endfunction

    // Address of one word inside a descriptor
    function [31:0] word_addr;
        input [31:0] desc;
        input [3:0]  ofs;
        begin
            word_addr = word_align(desc) + {28'h000_0000, ofs};
        end
    endfunction

    // True when word 0 hands the descriptor to the engine
    function mac_owned;
        input [31:0] word0;
        begin
            mac_owned = (word0[`OWN_HI:`OWN_LO] == `OWN_MAC);
        end
    endfunction

    // Frame shorter than the minimum length
    function is_runt;
        input [15:0] bytes;
        begin
            is_runt = (bytes < `MIN_FRAME_BYTES);
        end
    endfunction

    // Frame longer than the maximum length
    function is_long;
        input [15:0] bytes;
        begin
            is_long = (bytes > `MAX_FRAME_BYTES);
        end
    endfunction

    // Reported count with optional check-sequence strip
    function [15:0] report_count;
        input [15:0] bytes;
        input        strip;
        begin
            if (strip && bytes >= `FCS_BYTES)
                report_count = bytes - `FCS_BYTES;
            else
                report_count = bytes;
        end
    endfunction

    // Build whole word 0 for write-back
    function [31:0] build_status;
        input [15:0] bytes;
        input        strip;
        input        odd;
        input        crc;
        input        evt;
        input        xl;
        reg   [31:0] w;
        begin
            w = 32'h0000_0000;
            w[`OWN_HI:`OWN_LO] = xl ? `OWN_XLATE : `OWN_HOST;
            w[`RUNT_BIT]  = is_runt(bytes);
            w[`ALIGN_BIT] = odd;
            w[`DONE_BIT]  = 1'b1;
            w[`LONG_BIT]  = is_long(bytes);
            w[`CRC_BIT]   = crc;
            w[`EVENT_BIT] = evt;
            w[15:0] = report_count(bytes, strip);
            build_status = w;
        end
    endfunction

    // --------------------------------------------------------------
    // Handshake and write-back word
    // --------------------------------------------------------------
    // Frames are taken only while a buffer is loaded
    assign frame_ready = (state == S_RECV);

    // Whole word 0 built from the frame report
    always @*
    begin
        next_status = build_status(frame_bytes, strip_check_sequence,
                                   frame_odd_bits, frame_crc_bad,
                                   frame_event, frame_xlate);
    end

    // --------------------------------------------------------------
    // Descriptor walk
    // --------------------------------------------------------------
    always @(posedge clk)
    begin
        // All outputs cleared while reset is low
        if (!resetn)
        begin
            state                   <= S_IDLE;
            mem_req                 <= 1'b0;
            mem_we                  <= 1'b0;
            mem_addr                <= 32'h0000_0000;
            mem_wdata               <= 32'h0000_0000;
            buffer_valid            <= 1'b0;
            receive_buffer_base     <= 32'h0000_0000;
            byte_offset_field       <= 2'h0;
            current_descriptor      <= 32'h0000_0000;
            next_descriptor_pointer <= 32'h0000_0000;
            descriptor_wait         <= 1'b0;
        end
        else
        begin
            case (state)
                // Wait for enable, then fetch the first word 0
                S_IDLE:
                begin
                    if (enable)
                    begin
                        current_descriptor <= word_align(first_descriptor);
                        mem_addr <= word_align(first_descriptor);
                        mem_req  <= 1'b1;
                        mem_we   <= 1'b0;
                        state    <= S_RD0;
                    end
                end

                // Ownership check on word 0
                S_RD0:
                begin
                    if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        // only a MAC-owned descriptor is used
                        if (mac_owned(mem_rdata))
                        begin
                            descriptor_wait <= 1'b0;
                            mem_addr <= word_addr(current_descriptor,
                                                  `DESC_W1_OFS);
                            mem_req  <= 1'b1;
                            state    <= S_RD1;
                        end
                        else
                        begin
                            descriptor_wait <= 1'b1;
                            state <= S_POLL;
                        end
                    end
                end

                // One idle cycle between polls
                S_POLL:
                begin
                    // Re-read word 0 until host returns it
                    mem_addr <= current_descriptor;
                    mem_req  <= enable;
                    if (enable)
                        state <= S_RD0;
                    else
                        state <= S_IDLE;
                end

                // Buffer address from word 1
                S_RD1:
                begin
                    if (mem_ack)
                    begin
                        receive_buffer_base <= word_align(mem_rdata);
                        byte_offset_field   <= mem_rdata[1:0];
                        mem_addr <= word_addr(current_descriptor,
                                              `DESC_W3_OFS);
                        state    <= S_RD3;
                    end
                end

                // Link from word 3
                S_RD3:
                begin
                    if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        next_descriptor_pointer <= word_align(mem_rdata);
                        // Buffer now handed to the receive path
                        buffer_valid <= 1'b1;
                        state        <= S_RECV;
                    end
                end

                // Frame stored, start the word 0 write
                S_RECV:
                begin
                    if (frame_done)
                    begin
                        buffer_valid <= 1'b0;
                        // Status and ownership in a single word
                        mem_wdata <= next_status;
                        mem_addr <= current_descriptor;
                        mem_we   <= 1'b1;
                        mem_req  <= 1'b1;
                        state    <= S_WB;
                    end
                end

                // Write done, move along the list
                S_WB:
                begin
                    if (mem_ack)
                    begin
                        mem_we             <= 1'b0;
                        current_descriptor <= next_descriptor_pointer;
                        mem_addr           <= next_descriptor_pointer;
                        mem_req            <= enable;
                        state <= enable ? S_RD0 : S_IDLE;
                    end
                end

                // Unused codes fall back to idle
                default:
                begin
                    state   <= S_IDLE;
                    mem_req <= 1'b0;
                end
            endcase
        end
    end

endmodule

// [test/rx_desc_properties.sv]
`timescale 1ns/1ps
module rx_desc_props (
    input wire        clk, resetn, strip_check_sequence, frame_done,
    input wire [15:0] frame_bytes,
    input wire        frame_odd_bits, frame_crc_bad, frame_event,
    input wire        frame_xlate, frame_ready, mem_req, mem_we, mem_ack,
    input wire [31:0] mem_addr, mem_wdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Frame taken, then its word 0 writeback
    sequence s_take; frame_ready && frame_done; endsequence
    sequence s_wb; mem_req && mem_we; endsequence
    property p_done; s_take |=> s_wb ##0 mem_wdata[20]; endproperty
    a_done: assert property (p_done) else $error("no writeback");
    property p_own; s_wb |-> mem_wdata[31] == mem_wdata[30]; endproperty
    a_own: assert property (p_own) else $error("owner");
    property p_resv; s_wb |-> !mem_wdata[18] && !mem_wdata[29:23];
    endproperty
    a_resv: assert property (p_resv) else $error("reserved");
    property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
        && $stable(mem_wdata) && $stable(mem_we); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_size; s_take |=> mem_wdata[22] == ($past(frame_bytes) <
        16'h0040) && mem_wdata[19] == ($past(frame_bytes) > 16'h05ee);
    endproperty
    a_size: assert property (p_size) else $error("size");
    property p_flag; s_take |=> mem_wdata[21] == $past(frame_odd_bits) &&
        mem_wdata[17] == $past(frame_crc_bad) &&
        mem_wdata[16] == $past(frame_event); endproperty
    a_flag: assert property (p_flag) else $error("flags");
    property p_xl; s_take |=> mem_wdata[31] == $past(frame_xlate);
    endproperty
    a_xl: assert property (p_xl) else $error("xlate");
    property p_cnt; s_take |=> mem_wdata[15:0] == $past(frame_bytes) -
        ($past(strip_check_sequence) && $past(frame_bytes) > 16'h0003 ?
        16'h0004 : 16'h0000); endproperty
    a_cnt: assert property (p_cnt) else $error("count");
endmodule
bind rx_descriptor_status_writeback rx_desc_props u_props (.*);

// [test/desc_mem_model.sv]
`timescale 1ns/1ps
module desc_mem_model (
    input wire        clk, resetn, mem_req, mem_we,
    input wire [31:0] mem_addr, mem_wdata,
    output reg        mem_ack,
    output reg [31:0] mem_rdata
);
    reg [31:0] mem [0:15]; // Four descriptors of four words
    reg [1:0]  cnt;
    reg        slow;
    initial mem_rdata = 32'h0;
    // Prompt and slow answers in turn; idle data toggles
    always @(posedge clk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (!resetn)
            {cnt, slow} <= 3'h0;
        else if (mem_req && !mem_ack && cnt != {slow, slow})
            cnt <= cnt + 2'h1;
        else if (mem_req && !mem_ack)
        begin
            {mem_ack, cnt, slow} <= {3'h4, ~slow};
            mem_rdata <= mem[mem_addr[5:2]];
            if (mem_we)
                mem[mem_addr[5:2]] <= mem_wdata;
        end
    end
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    reg         clk = 0, resetn = 0, enable = 0, strip = 0, done = 0;
    reg         odd = 0, crc = 0, evt = 0, xl = 0;
    reg  [15:0] bytes = 16'h0;
    wire        ready, req, we, ack, dwait, bval;
    wire [31:0] base, addr, wdata, rdata, cur;
    wire [1:0]  ofs;
    integer     err_count = 0, check_count = 0, i, k;
    rx_descriptor_status_writeback dut (.clk(clk), .resetn(resetn),
        .enable(enable), .strip_check_sequence(strip),
        .first_descriptor(32'h0), .frame_done(done), .frame_bytes(bytes),
        .frame_odd_bits(odd), .frame_crc_bad(crc), .frame_event(evt),
        .frame_xlate(xl), .frame_ready(ready), .buffer_valid(bval),
        .receive_buffer_base(base), .byte_offset_field(ofs), .mem_req(req),
        .mem_we(we), .mem_addr(addr), .mem_wdata(wdata), .mem_ack(ack),
        .mem_rdata(rdata), .current_descriptor(cur), .descriptor_wait(dwait));
    desc_mem_model mdl (.clk(clk), .resetn(resetn), .mem_req(req),
        .mem_we(we), .mem_addr(addr), .mem_wdata(wdata), .mem_ack(ack),
        .mem_rdata(rdata));
    always #5 clk = ~clk;
    task chk(input [39:0] nm, input [31:0] e, g);
    begin
        check_count = check_count + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("wrong value %0s exp %h got %h", nm, e, g);
        end
    end
    endtask
    // One frame into descriptor d, then its word 0 judged
    task frame(input [5:0] d, input [15:0] n, input s, o, c, e, x);
    begin
        for (k = 0; ready !== 1'b1 && k < 200; k = k + 1)
            @(posedge clk) #1;
        chk("cur", {26'h0, d}, cur);
        chk("bval", 32'h1, {31'h0, bval});
        chk("buf", mdl.mem[d[5:2] + 4'h1], base | ofs);
        {strip, odd, crc, evt, xl, bytes, done} = {s, o, c, e, x, n, 1'b1};
        @(posedge clk) #1 done = 1'b0;
        for (k = 0; mdl.mem[d[5:2]][31:30] === 2'b10 && k < 50; k = k + 1)
            @(posedge clk) #1;
        chk("word0", {x, x, 7'h0, n < 16'h0040, o, 1'b1,
            n > 16'h05ee, 1'b0, c, e, s && n > 3 ? n - 16'h4 : n},
            mdl.mem[d[5:2]]);
    end
    endtask
    // Engine parks on a descriptor it does not own
    task wait_host;
    begin
        for (k = 0; dwait !== 1'b1 && k < 100; k = k + 1)
            @(posedge clk) #1;
        chk("wait", 32'h1, {31'h0, dwait});
        chk("ready", 32'h0, {31'h0, ready});
        chk("bval", 32'h0, {31'h0, bval});
        // A completion while parked must be ignored
        done = 1'b1;
        @(posedge clk) #1 done = 1'b0;
        chk("we", 32'h0, {31'h0, we});
    end
    endtask
    task t_sizes;
    begin
        frame(6'h00, 16'd63, 0, 1, 0, 0, 1);
        frame(6'h10, 16'd64, 1, 0, 1, 0, 0);
    end
    endtask
    task t_poll;
    begin
        wait_host;
        mdl.mem[8] = 32'h8000_0000;
        frame(6'h20, 16'd1518, 0, 0, 0, 1, 0);
    end
    endtask
    task t_long;
    begin
        frame(6'h30, 16'd1519, 1, 0, 1, 1, 1);
        wait_host;
    end
    endtask
    task summarize;
    begin
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    // Ring of four descriptors, third one host owned
    initial
    begin
        for (i = 0; i < 4; i = i + 1)
            {mdl.mem[4 * i], mdl.mem[4 * i + 1], mdl.mem[4 * i + 2],
                mdl.mem[4 * i + 3]} = {(i == 2) ? 32'h0 : 32'h8000_0000,
                32'h0000_0201 + i, 32'h5a5a_a5a5, 32'h0 + (i + 1) % 4 * 16 + 2};
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        enable = 1'b1;
        t_sizes;
        t_poll;
        t_long;
        summarize;
    end
    // Watchdog
    initial
    begin
        #100000;
        err_count = err_count + 1;
        summarize;
    end
endmodule
